// [lpmcg_clkdiv.sv]
// lpmcg_clkdiv.sv - programmable clock divider producing one-cycle enable pulses
`timescale 1ns/10ps
`default_nettype none

module lpmcg_clkdiv #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	// control
	input  wire logic         run_i,
	input  wire logic [W-1:0] div_i,
	// divided enable
	output logic              tick_o
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_r;
	logic         tick_nxt;

	// divide by div_i; zero stops the clock altogether
	always_comb
	begin
		cnt_nxt  = '0;
		tick_nxt = 1'b0;
		if (run_i && (div_i != '0))
		begin
			if (cnt_r >= W'(div_i - 1'b1))
				tick_nxt = 1'b1;
			else
				cnt_nxt = W'(cnt_r + 1'b1);
		end
	end

	// registers only
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;

endmodule // lpmcg_clkdiv

`default_nettype wire

// [lpmcg_core_model.sv]
// lpmcg_core_model.sv - processor core stand-in that raises sleep requests and interrupts
`timescale 1ns/10ps
`default_nettype none

module lpmcg_core_model (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	// commands from the bench
	input  wire logic go_i,
	input  wire logic deep_i,
	input  wire logic irq_i,
	// towards the controller
	output logic      sleep_req_o,
	output logic      sleep_deep_o,
	output logic      irq_pending_o
);
	// ----------------------------------------------------------------
	// core request side
	// ----------------------------------------------------------------
	// depth travels with the request; a held request would re-enter sleep
	always_ff @(posedge mclk_i)
	begin
		sleep_req_o   <= go_i & ~sys_rst_i;
		sleep_deep_o  <= deep_i;
		irq_pending_o <= irq_i & ~sys_rst_i;
	end
endmodule // lpmcg_core_model

`default_nettype wire

// [lpmcg_pkg.sv]
// lpmcg_pkg.sv - shared constants and types of the low power mode and clock gating block
`default_nettype none

package lpmcg_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_PCLK_EN = 8'h04;
	localparam logic [7:0] REG_SRC_EN  = 8'h08;
	localparam logic [7:0] REG_SYSCLK  = 8'h0C;
	localparam logic [7:0] REG_PDIV0   = 8'h10;
	localparam logic [7:0] REG_WAKE_EN = 8'h20;
	localparam logic [7:0] REG_STATUS  = 8'h24;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_KEEP_WDT_OSC = 0;
	localparam int CTRL_KEEP_BOD     = 1;
	localparam int CTRL_WDT_SEL_IRC  = 2;
	localparam int SYS_SRC_LSB       = 0;
	localparam int SYS_PLL_LSB       = 8;
	localparam int SYS_DIV_LSB       = 16;
	localparam int STAT_CAUSE_LSB    = 8;
	localparam int SRC_IRC_IDX       = 0;
	localparam int SRC_WDT_OSC_IDX   = 1;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] PCLK_EN_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] SRC_EN_RST  = 32'h0000_0001;
	localparam logic [31:0] SYSCLK_RST  = 32'h0001_0000;
	localparam logic [31:0] PDIV_RST    = 32'h0000_0001;
	localparam logic [31:0] WAKE_EN_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing: settle time of restored clock sources before core release
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int WAKE_SETTLE_NS  = 1000;
	localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// power state machine
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_SLEEP  = 4'h2,
		ST_DEEP   = 4'h4,
		ST_WAKE   = 4'h8
	} lpmcg_state_t;

endpackage : lpmcg_pkg

`default_nettype wire

// [lpmcg_top.sv]
// lpmcg_top.sv - power mode sequencer and clock gating controller with Avalon-MM registers
//
// Function
// - sleep entry stops the core clock only
// - sleep exit just re-enables core clock
// - sleeping core waits for reset or interrupt
// - peripheral clocks keep running during sleep
// - deep sleep: all clocks off except RC
// - deep sleep: RC output gated unless it feeds watchdog
// - deep sleep: analog shutdown, flash standby
// - option keeps watchdog oscillator and brownout running
// - deep wake: reset, GPIO, watchdog, USB
// - register gates each peripheral clock individually
// - selected peripherals get programmable clock dividers
// - system clock source, PLL, divider adjustable
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module lpmcg_top #(
	parameter int NPERIPH = 8,
	parameter int NSRC    = 4,
	parameter int NDIV    = 2,
	parameter int NGPIO   = 4,
	parameter int DIV_W   = 8
) (
	// clock and reset
	input  wire logic               mclk_i,
	input  wire logic               sys_rst_i,
	// Avalon-MM slave
	input  wire logic [7:0]         avs_address_i,
	input  wire logic               avs_read_i,
	input  wire logic               avs_write_i,
	input  wire logic [31:0]        avs_writedata_i,
	input  wire logic [3:0]         avs_byteenable_i,
	output logic      [31:0]        avs_readdata_o,
	output logic                    avs_waitrequest_o,
	// processor core
	input  wire logic               sleep_req_i,
	input  wire logic               sleep_deep_i,
	input  wire logic               irq_pending_i,
	output logic                    core_clk_en_o,
	// wake sources
	input  wire logic [NGPIO-1:0]   gpio_wake_i,
	input  wire logic               wdt_irq_i,
	input  wire logic               usb_act_i,
	// clock gating
	output logic [NPERIPH-1:0]      pclk_en_o,
	output logic [NDIV-1:0]         pdiv_tick_o,
	output logic [NSRC-1:0]         clksrc_en_o,
	output logic                    internal_rc_oscillator_out_en_o,
	output logic [1:0]              sys_src_sel_o,
	output logic [7:0]              pll_cfg_o,
	// analog and memory power
	output logic                    analog_shdn_o,
	output logic                    flash_stby_o,
	output logic                    brownout_detector_en_o
);

	localparam int NCAUSE = NGPIO + 2;
	localparam int WBITS  = 8;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// merge a write into a register under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
	                                         input logic [31:0] new_v,
	                                         input logic [3:0]  be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
			if (be[b])
				res[b*8 +: 8] = new_v[b*8 +: 8];
		return res;
	endfunction

	// word index of a byte address
	function automatic logic [5:0] widx(input logic [7:0] a);
		return a[7:2];
	endfunction

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [2:0]             ctrl_r,    ctrl_nxt;
	logic [NPERIPH-1:0]     pclk_r,    pclk_nxt;
	logic [NSRC-1:0]        src_r,     src_nxt;
	logic [1:0]             ssel_r,    ssel_nxt;
	logic [7:0]             pll_r,     pll_nxt;
	logic [DIV_W-1:0]       cdiv_r,    cdiv_nxt;
	logic [DIV_W-1:0]       pdiv_r     [NDIV];
	logic [DIV_W-1:0]       pdiv_nxt   [NDIV];
	logic [NCAUSE-1:0]      wken_r,    wken_nxt;
	logic [NCAUSE-1:0]      cause_r,   cause_nxt;
	logic [31:0]            rdata_r,   rdata_nxt;
	logic                   ack_r,     ack_nxt;

	logic                   req;
	logic                   wr_go;
	logic [31:0]            wmerge;
	logic [NCAUSE-1:0]      wake_vec;
	logic                   wake_evt;

	lpmcg_pkg::lpmcg_state_t st_r, st_nxt;
	logic [WBITS-1:0]       wcnt_r,    wcnt_nxt;

	// ----------------------------------------------------------------
	// bus slave: every access answers one cycle after it is raised
	// ----------------------------------------------------------------
	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_r;
	assign wr_go             = avs_write_i & ack_r;
	assign avs_readdata_o    = rdata_r;

	// wake event vector: gpio pins, watchdog, usb
	assign wake_vec = {usb_act_i, wdt_irq_i, gpio_wake_i};
	assign wake_evt = |(wake_vec & wken_r);

	// register write decode and read mux
	always_comb
	begin
		ctrl_nxt  = ctrl_r;
		pclk_nxt  = pclk_r;
		src_nxt   = src_r;
		ssel_nxt  = ssel_r;
		pll_nxt   = pll_r;
		cdiv_nxt  = cdiv_r;
		pdiv_nxt  = pdiv_r;
		wken_nxt  = wken_r;
		cause_nxt = cause_r;
		rdata_nxt = rdata_r;
		ack_nxt   = req & ~ack_r;
		wmerge    = 32'h0000_0000;
		if (wr_go)
		begin
			case (widx(avs_address_i))
				widx(lpmcg_pkg::REG_CTRL):
				begin
					wmerge   = be_merge({29'h0, ctrl_r}, avs_writedata_i, avs_byteenable_i);
					ctrl_nxt = wmerge[2:0];
				end
				widx(lpmcg_pkg::REG_PCLK_EN):
				begin
					wmerge   = be_merge(32'(pclk_r), avs_writedata_i, avs_byteenable_i);
					pclk_nxt = wmerge[NPERIPH-1:0];
				end
				widx(lpmcg_pkg::REG_SRC_EN):
				begin
					wmerge  = be_merge(32'(src_r), avs_writedata_i, avs_byteenable_i);
					src_nxt = wmerge[NSRC-1:0];
				end
				widx(lpmcg_pkg::REG_SYSCLK):
				begin
					wmerge   = be_merge({8'h0, 8'(cdiv_r), pll_r, 6'h0, ssel_r},
					                    avs_writedata_i, avs_byteenable_i);
					ssel_nxt = wmerge[lpmcg_pkg::SYS_SRC_LSB +: 2];
					pll_nxt  = wmerge[lpmcg_pkg::SYS_PLL_LSB +: 8];
					cdiv_nxt = wmerge[lpmcg_pkg::SYS_DIV_LSB +: DIV_W];
				end
				widx(lpmcg_pkg::REG_WAKE_EN):
				begin
					wmerge   = be_merge(32'(wken_r), avs_writedata_i, avs_byteenable_i);
					wken_nxt = wmerge[NCAUSE-1:0];
				end
				widx(lpmcg_pkg::REG_STATUS):
				begin
					// write one to clear a cause bit
					if (avs_byteenable_i[1])
						cause_nxt = cause_r & ~avs_writedata_i[lpmcg_pkg::STAT_CAUSE_LSB +: NCAUSE];
				end
				default:
				begin
					for (int i = 0; i < NDIV; i++)
						if (widx(avs_address_i) == widx(8'(lpmcg_pkg::REG_PDIV0 + 4 * i)))
						begin
							wmerge      = be_merge(32'(pdiv_r[i]), avs_writedata_i,
							                       avs_byteenable_i);
							pdiv_nxt[i] = wmerge[DIV_W-1:0];
						end
				end
			endcase
		end
		// a cause seen in deep sleep wins over a clear in the same cycle
		if (st_r == lpmcg_pkg::ST_DEEP)
			cause_nxt = cause_nxt | (wake_vec & wken_r);
		// read data captured in the cycle before the answer
		if (avs_read_i && !ack_r)
		begin
			rdata_nxt = 32'h0000_0000;
			case (widx(avs_address_i))
				widx(lpmcg_pkg::REG_CTRL):    rdata_nxt = {29'h0, ctrl_r};
				widx(lpmcg_pkg::REG_PCLK_EN): rdata_nxt = 32'(pclk_r);
				widx(lpmcg_pkg::REG_SRC_EN):  rdata_nxt = 32'(src_r);
				widx(lpmcg_pkg::REG_SYSCLK):  rdata_nxt = {8'h0, 8'(cdiv_r), pll_r, 6'h0, ssel_r};
				widx(lpmcg_pkg::REG_WAKE_EN): rdata_nxt = 32'(wken_r);
				widx(lpmcg_pkg::REG_STATUS):
					rdata_nxt = {16'h0, 8'(cause_r), 4'h0, st_r};
				default:
				begin
					for (int i = 0; i < NDIV; i++)
						if (widx(avs_address_i) == widx(8'(lpmcg_pkg::REG_PDIV0 + 4 * i)))
							rdata_nxt = 32'(pdiv_r[i]);
				end
			endcase
		end
	end

	// register file flops
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_r  <= lpmcg_pkg::CTRL_RST[2:0];
			pclk_r  <= lpmcg_pkg::PCLK_EN_RST[NPERIPH-1:0];
			src_r   <= lpmcg_pkg::SRC_EN_RST[NSRC-1:0];
			ssel_r  <= lpmcg_pkg::SYSCLK_RST[lpmcg_pkg::SYS_SRC_LSB +: 2];
			pll_r   <= lpmcg_pkg::SYSCLK_RST[lpmcg_pkg::SYS_PLL_LSB +: 8];
			cdiv_r  <= lpmcg_pkg::SYSCLK_RST[lpmcg_pkg::SYS_DIV_LSB +: DIV_W];
			for (int i = 0; i < NDIV; i++)
				pdiv_r[i] <= lpmcg_pkg::PDIV_RST[DIV_W-1:0];
			wken_r  <= lpmcg_pkg::WAKE_EN_RST[NCAUSE-1:0];
			cause_r <= '0;
			rdata_r <= 32'h0000_0000;
			ack_r   <= 1'b0;
		end
		else
		begin
			ctrl_r  <= ctrl_nxt;
			pclk_r  <= pclk_nxt;
			src_r   <= src_nxt;
			ssel_r  <= ssel_nxt;
			pll_r   <= pll_nxt;
			cdiv_r  <= cdiv_nxt;
			pdiv_r  <= pdiv_nxt;
			wken_r  <= wken_nxt;
			cause_r <= cause_nxt;
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
		end
	end

	// ----------------------------------------------------------------
	// power state machine
	// ----------------------------------------------------------------

	// sleep exits on any interrupt; deep sleep only on enabled wake sources
	always_comb
	begin
		st_nxt   = st_r;
		wcnt_nxt = wcnt_r;
		case (st_r)
			lpmcg_pkg::ST_ACTIVE:
			begin
				if (sleep_req_i)
					st_nxt = sleep_deep_i ? lpmcg_pkg::ST_DEEP : lpmcg_pkg::ST_SLEEP;
			end
			lpmcg_pkg::ST_SLEEP:
			begin
				if (irq_pending_i)
					st_nxt = lpmcg_pkg::ST_ACTIVE;
			end
			lpmcg_pkg::ST_DEEP:
			begin
				if (wake_evt)
				begin
					st_nxt   = lpmcg_pkg::ST_WAKE;
					wcnt_nxt = WBITS'(lpmcg_pkg::WAKE_SETTLE_CYC - 1);
				end
			end
			lpmcg_pkg::ST_WAKE:
			begin
				// sources must settle before the core may run again
				if (wcnt_r == '0)
					st_nxt = lpmcg_pkg::ST_ACTIVE;
				else
					wcnt_nxt = WBITS'(wcnt_r - 1'b1);
			end
			default:
				st_nxt = lpmcg_pkg::ST_ACTIVE;
		endcase
	end

	// state flops
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_r   <= lpmcg_pkg::ST_ACTIVE;
			wcnt_r <= '0;
		end
		else
		begin
			st_r   <= st_nxt;
			wcnt_r <= wcnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// gating outputs, registered from the next state
	// ----------------------------------------------------------------
	logic                core_run_r,  core_run_nxt;
	logic [NPERIPH-1:0]  pclk_o_r,    pclk_o_nxt;
	logic [NSRC-1:0]     src_o_r,     src_o_nxt;
	logic                irc_r,       irc_nxt;
	logic                shdn_r,      shdn_nxt;
	logic                bod_r,       bod_nxt;
	logic                deep_nxt;
	logic [NSRC-1:0]     keep_mask;

	// in deep sleep only the RC oscillator, plus the watchdog oscillator if kept
	always_comb
	begin
		keep_mask                             = '0;
		keep_mask[lpmcg_pkg::SRC_IRC_IDX]     = 1'b1;
		keep_mask[lpmcg_pkg::SRC_WDT_OSC_IDX] = ctrl_r[lpmcg_pkg::CTRL_KEEP_WDT_OSC];
		deep_nxt     = (st_nxt == lpmcg_pkg::ST_DEEP);
		core_run_nxt = (st_nxt == lpmcg_pkg::ST_ACTIVE);
		pclk_o_nxt   = deep_nxt ? '0 : pclk_r;
		src_o_nxt    = deep_nxt ? (src_r & keep_mask) : src_r;
		irc_nxt      = deep_nxt ? ctrl_r[lpmcg_pkg::CTRL_WDT_SEL_IRC] : 1'b1;
		shdn_nxt     = deep_nxt;
		bod_nxt      = ~deep_nxt | ctrl_r[lpmcg_pkg::CTRL_KEEP_BOD];
	end

	// output flops
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			core_run_r <= 1'b1;
			pclk_o_r   <= lpmcg_pkg::PCLK_EN_RST[NPERIPH-1:0];
			src_o_r    <= lpmcg_pkg::SRC_EN_RST[NSRC-1:0];
			irc_r      <= 1'b1;
			shdn_r     <= 1'b0;
			bod_r      <= 1'b1;
		end
		else
		begin
			core_run_r <= core_run_nxt;
			pclk_o_r   <= pclk_o_nxt;
			src_o_r    <= src_o_nxt;
			irc_r      <= irc_nxt;
			shdn_r     <= shdn_nxt;
			bod_r      <= bod_nxt;
		end
	end

	assign pclk_en_o                       = pclk_o_r;
	assign clksrc_en_o                     = src_o_r;
	assign internal_rc_oscillator_out_en_o = irc_r;
	assign analog_shdn_o                   = shdn_r;
	assign flash_stby_o                    = shdn_r;
	assign brownout_detector_en_o          = bod_r;
	assign sys_src_sel_o                   = ssel_r;
	assign pll_cfg_o                       = pll_r;

	// ----------------------------------------------------------------
	// dividers: core clock and selected peripheral clocks
	// ----------------------------------------------------------------

	// core clock divider stops while the core is gated
	lpmcg_clkdiv #(.W(DIV_W)) u_core_div (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (core_run_r),
		.div_i     (cdiv_r),
		.tick_o    (core_clk_en_o)
	);

	// peripheral dividers idle in deep sleep
	for (genvar g = 0; g < NDIV; g++)
	begin : g_pdiv
		lpmcg_clkdiv #(.W(DIV_W)) u_pdiv (
			.mclk_i    (mclk_i),
			.sys_rst_i (sys_rst_i),
			.run_i     (~shdn_r),
			.div_i     (pdiv_r[g]),
			.tick_o    (pdiv_tick_o[g])
		);
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	localparam int WAKE_MAX = 300;

	a_sleep_gates_core:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_ACTIVE && sleep_req_i && !sleep_deep_i)
		|=> (st_r == lpmcg_pkg::ST_SLEEP) && !core_run_r ##1 !core_clk_en_o)
	else $error("core clock not stopped on sleep entry");

	a_sleep_irq_exit:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_SLEEP && irq_pending_i)
		|=> (st_r == lpmcg_pkg::ST_ACTIVE) && core_run_r)
	else $error("interrupt did not resume core from sleep");

	a_sleep_holds_core:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_SLEEP && !irq_pending_i) |=> !core_run_r)
	else $error("core clock resumed without interrupt");

	a_sleep_pclk_on:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_SLEEP && $past(st_r) == lpmcg_pkg::ST_SLEEP)
		|-> pclk_en_o == $past(pclk_r))
	else $error("peripheral clocks changed in sleep");

	a_deep_clocks_off:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_DEEP)
		|-> pclk_en_o == '0 && !core_run_r && (clksrc_en_o & ~$past(keep_mask)) == '0)
	else $error("clock still running in deep sleep");

	a_deep_irc_gate:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_DEEP)
		|-> internal_rc_oscillator_out_en_o == $past(ctrl_r[lpmcg_pkg::CTRL_WDT_SEL_IRC]))
	else $error("rc oscillator output not gated in deep sleep");

	a_deep_analog_off:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(st_r == lpmcg_pkg::ST_DEEP) |-> analog_shdn_o && flash_stby_o)
	else $error("analog or flash not powered down in deep sleep");

	a_deep_keep_opt:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_DEEP)
		|-> brownout_detector_en_o == $past(ctrl_r[lpmcg_pkg::CTRL_KEEP_BOD]))
	else $error("brownout enable does not follow keep option");

	a_deep_wake_src:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_DEEP && wake_evt) |=> (st_r == lpmcg_pkg::ST_WAKE)
		##[1:WAKE_MAX] (st_r == lpmcg_pkg::ST_ACTIVE))
	else $error("deep sleep wake sequence did not complete");

	a_wake_restore:
	assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_r == lpmcg_pkg::ST_WAKE)
		|-> !core_run_r && clksrc_en_o == $past(src_r) && pclk_en_o == $past(pclk_r))
	else $error("clocks not restored before core release");

endmodule // lpmcg_top

`default_nettype wire

// [tb.sv]
// tb.sv - self-checking bench of the power mode and clock gating controller
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic        mclk_i = 1'h0;
	logic        sys_rst_i = 1'h1;
	logic [7:0]  avs_address_i = 8'h00;
	logic        avs_read_i = 1'h0;
	logic        avs_write_i = 1'h0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        go = 1'h0, deep = 1'h0, irq = 1'h0;
	logic        sleep_req, sleep_deep, irq_pending, core_clk_en_o;
	logic [3:0]  gpio_wake_i = 4'h0;
	logic        wdt_irq_i = 1'h0, usb_act_i = 1'h0;
	logic [7:0]  pclk_en_o, pll_cfg_o;
	logic [1:0]  pdiv_tick_o, sys_src_sel_o;
	logic [3:0]  clksrc_en_o, es;
	logic        rc_en_o, shdn_o, stby_o, bod_o;
	logic [31:0] rd, c;
	int          num_errors = 0;
	int          total_checks = 0;
	int          nc, nd, np, n;
	logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h30};
	logic [31:0] re [8] = '{32'h0, 32'hFF, 32'h1, 32'h1_0000, 32'h1, 32'h0, 32'h1, 32'h0};
	logic [31:0] dv [3] = '{32'h0000_3402, 32'h0002_3402, 32'h0001_3402};
	int          de [3] = '{0, 10, 20};
	logic [5:0]  wc [3] = '{6'h01, 6'h10, 6'h20};

	always #2.5 mclk_i = ~mclk_i;

	lpmcg_core_model core (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .go_i(go), .deep_i(deep),
		.irq_i(irq), .sleep_req_o(sleep_req), .sleep_deep_o(sleep_deep),
		.irq_pending_o(irq_pending));

	lpmcg_top DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .sleep_req_i(sleep_req),
		.sleep_deep_i(sleep_deep), .irq_pending_i(irq_pending), .core_clk_en_o(core_clk_en_o),
		.gpio_wake_i(gpio_wake_i), .wdt_irq_i(wdt_irq_i), .usb_act_i(usb_act_i),
		.pclk_en_o(pclk_en_o), .pdiv_tick_o(pdiv_tick_o), .clksrc_en_o(clksrc_en_o),
		.internal_rc_oscillator_out_en_o(rc_en_o), .sys_src_sel_o(sys_src_sel_o),
		.pll_cfg_o(pll_cfg_o), .analog_shdn_o(shdn_o), .flash_stby_o(stby_o),
		.brownout_detector_en_o(bod_o));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one idle edge first, so a release and a new request never share a time step
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge mclk_i);
		avs_address_i   <= a;
		avs_writedata_i <= wd;
		avs_write_i     <= wr;
		avs_read_i      <= ~wr;
		k = 0;
		do
		begin
			@(posedge mclk_i);
			k++;
		end
		while (avs_waitrequest_o !== 1'h0 && k < 50);
		rd = avs_readdata_o;
		avs_read_i  <= 1'h0;
		avs_write_i <= 1'h0;
		if (k >= 50)
			chk("bus answer", 32'h1, 32'h0);
	endtask

	// counts core enables and both divider ticks over a window
	task automatic cnt(input int w);
		nc = 0;
		nd = 0;
		np = 0;
		repeat (w)
		begin
			@(posedge mclk_i);
			nc += (core_clk_en_o === 1'h1);
			nd += (pdiv_tick_o[0] === 1'h1);
			np += (pdiv_tick_o[1] === 1'h1);
		end
	endtask

	task automatic req_sleep(input logic d);
		@(posedge mclk_i);
		go   <= 1'h1;
		deep <= d;
		@(posedge mclk_i);
		go <= 1'h0;
		repeat (3) @(posedge mclk_i);
	endtask

	// ----------------------------------------------------------------
	// watchdog: the whole sequence needs well under ten microseconds
	// ----------------------------------------------------------------
	initial
	begin
		#50000;
		num_errors++;
		conclude();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		@(posedge mclk_i);
		chk("reset outputs", {clksrc_en_o, rc_en_o, shdn_o, stby_o, bod_o, pclk_en_o}, 16'h19FF);
		bus(1'h1, 8'h30, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'h0, ra[i], 32'h0);
			chk("reset register", rd, re[i]);
		end
		$display("test reset values done");

		bus(1'h1, lpmcg_pkg::REG_PCLK_EN, 32'hA5);
		// the gate flop follows the register one edge later
		repeat (2) @(posedge mclk_i);
		chk("pclk enables", pclk_en_o, 32'hA5);
		for (int i = 0; i < 3; i++)
		begin
			bus(1'h1, lpmcg_pkg::REG_SYSCLK, dv[i]);
			repeat (2) @(posedge mclk_i);
			cnt(20);
			chk("core pulses", nc, de[i]);
		end
		chk("source and pll", {sys_src_sel_o, pll_cfg_o}, 10'h234);
		bus(1'h1, lpmcg_pkg::REG_PDIV0, 32'h4);
		repeat (2) @(posedge mclk_i);
		cnt(20);
		chk("divider ticks", nd, 5);
		$display("test clock control done");

		req_sleep(1'h0);
		cnt(20);
		chk("sleep core", nc, 0);
		chk("sleep periph", {pclk_en_o, nd[7:0]}, 16'hA505);
		chk("sleep periph1", np, 20);
		irq <= 1'h1;
		repeat (4) @(posedge mclk_i);
		irq <= 1'h0;
		cnt(20);
		chk("resumed core", nc, 20);
		$display("test sleep done");

		bus(1'h1, lpmcg_pkg::REG_WAKE_EN, 32'h31);
		bus(1'h1, lpmcg_pkg::REG_SRC_EN, 32'h3);
		for (int k = 0; k < 3; k++)
		begin
			c = (k == 0) ? 32'h0 : 32'h7;
			es = c[0] ? 4'h3 : 4'h1;
			bus(1'h1, lpmcg_pkg::REG_CTRL, c);
			req_sleep(1'h1);
			chk("deep outputs", {clksrc_en_o, rc_en_o, shdn_o, stby_o, bod_o, pclk_en_o},
				{es, c[2], 2'h3, c[1], 8'h00});
			cnt(8);
			chk("deep clocks", nc + nd + np, 0);
			if (k == 0)
			begin
				irq <= 1'h1;
				gpio_wake_i[1] <= 1'h1;
				repeat (10) @(posedge mclk_i);
				irq <= 1'h0;
				gpio_wake_i[1] <= 1'h0;
				bus(1'h0, lpmcg_pkg::REG_STATUS, 32'h0);
				chk("deep holds", rd[13:0], 14'h0004);
			end
			@(posedge mclk_i);
			case (k)
				0: gpio_wake_i[0] <= 1'h1;
				1: wdt_irq_i <= 1'h1;
				default: usb_act_i <= 1'h1;
			endcase
			repeat (2) @(posedge mclk_i);
			gpio_wake_i[0] <= 1'h0;
			wdt_irq_i <= 1'h0;
			usb_act_i <= 1'h0;
			chk("restored", {clksrc_en_o, core_clk_en_o, pclk_en_o}, 13'h6A5);
			n = 0;
			while (core_clk_en_o !== 1'h1 && n < 300)
			begin
				@(posedge mclk_i);
				n++;
			end
			chk("settle bound", n > 190 && n < 300, 1'h1);
			bus(1'h0, lpmcg_pkg::REG_STATUS, 32'h0);
			chk("active again", rd[3:0], 4'h1);
			chk("wake cause", rd[13:8], wc[k]);
			bus(1'h1, lpmcg_pkg::REG_STATUS, 32'h0000_3F00);
		end
		bus(1'h0, lpmcg_pkg::REG_STATUS, 32'h0);
		chk("cause cleared", rd[13:0], 14'h0001);
		$display("test deep sleep done");
		conclude();
	end
endmodule // tb

`default_nettype wire
